// file: src/ggr_top.sv
/*
  global pin-function select, pin takeover and interrupt roll-up,
  with an apb slave for the registers.
  assumes the host waits on pready and that per-port status inputs are
  synchronous to mclk.
*/
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module ggr_top
  (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pinIn,
  output ggr_pkg::ggr_pins_t pinDrive,
  input wire logic [3:0] portAStatus,
  input wire logic [3:0] portBStatus,
  input wire ggr_pkg::ggr_stat_t statIn,
  input wire logic [1:0] perfUpdateMode,
  input wire logic ref8kOut,
  output logic perfUpdatePin,
  output logic errInsertPin,
  output logic ref8kIn,
  output logic irqOut,
  output logic irqOe
  );
  import ggr_pkg::*;

  // only the summary enables hold state; other bits read back 0
  localparam logic [15:0] IRQ_EN_WMASK = 16'(((1 << NPORTS) - 1) << PORT_SUM_LSB) |
                                         16'(1 << GLOB_SUM_BIT);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] pinSel_q;
  logic [15:0] irqEn_q;
  logic [3:0] globCtrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  ggr_pins_t pins_q;
  ggr_pins_t pins_d;
  logic [7:0] pinLive_q;
  logic [15:0] irqSum_q;
  logic [15:0] liveStat_q;
  logic irqOut_q;
  logic irqOe_q;
  logic updPin_q;
  logic errPin_q;
  logic refIn_q;

  function automatic logic [13:0] regAddr(input logic [11:0] idx);
    regAddr = {idx, 2'b00};
  endfunction

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire access = psel && penable && !pready_q;
  wire hitSel = paddr == regAddr(IDX_PIN_SEL);
  wire hitSum = paddr == regAddr(IDX_IRQ_SUM);
  wire hitEn = paddr == regAddr(IDX_IRQ_EN);
  wire hitStat = paddr == regAddr(IDX_LIVE_STAT);
  wire hitRead = paddr == regAddr(IDX_PIN_READ);
  wire hitCtrl = paddr == regAddr(IDX_GLOB_CTRL);
  wire mapped = hitSel | hitSum | hitEn | hitStat | hitRead | hitCtrl;
  wire wrEn = access && pwrite && mapped;
  wire [15:0] rdMux = hitSel ? pinSel_q :
                      hitSum ? irqSum_q :
                      hitEn ? irqEn_q :
                      hitStat ? liveStat_q :
                      hitRead ? {8'h00, pinLive_q} :
                      hitCtrl ? {12'h000, globCtrl_q} : 16'h0000;

  // ----------------------------------------
  // pin function
  // ----------------------------------------
  wire modeUpd = perfUpdateMode == PERF_MODE_PIN;
  wire errSel = globCtrl_q[CTRL_ERR_BIT];
  wire refInSel = globCtrl_q[CTRL_R8I_BIT];
  wire refOutSel = globCtrl_q[CTRL_R8O_BIT];
  // even index is odd-numbered pin: A status; odd index: B status
  wire [7:0] statusOf = {portBStatus[3], portAStatus[3], portBStatus[2], portAStatus[2],
                         portBStatus[1], portAStatus[1], portBStatus[0], portAStatus[0]};

  always_comb
  begin
    pins_d = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      unique case (ggr_fn_t'(pinSel_q[2*i +: 2]))
        FN_INPUT:
        begin
          pins_d.out[i] = 1'b0;
          pins_d.oe[i] = 1'b0;
        end
        FN_STATUS:
        begin
          pins_d.out[i] = statusOf[i];
          pins_d.oe[i] = 1'b1;
        end
        FN_LOW:
        begin
          pins_d.out[i] = 1'b0;
          pins_d.oe[i] = 1'b1;
        end
        FN_HIGH:
        begin
          pins_d.out[i] = 1'b1;
          pins_d.oe[i] = 1'b1;
        end
      endcase
    end
    // takeovers override the select field
    if (modeUpd)
    begin
      pins_d.out[PIN_UPD_IN] = 1'b0;
      pins_d.oe[PIN_UPD_IN] = 1'b0;
    end
    if (errSel)
    begin
      pins_d.out[PIN_ERR_IN] = 1'b0;
      pins_d.oe[PIN_ERR_IN] = 1'b0;
    end
    if (refInSel)
    begin
      pins_d.out[PIN_REF_IN] = 1'b0;
      pins_d.oe[PIN_REF_IN] = 1'b0;
    end
    if (refOutSel)
    begin
      pins_d.out[PIN_REF_OUT] = ref8kOut;
      pins_d.oe[PIN_REF_OUT] = 1'b1;
    end
  end

  // live level: driven value where driven, else the pad input
  wire [7:0] pinLive_d = (pins_q.oe & pins_q.out) | (~pins_q.oe & pinIn);

  // ----------------------------------------
  // interrupt roll-up
  // ----------------------------------------
  wire [3:0] portSum = statIn.portIrqAny;
  wire globSum = statIn.latchedAny;
  wire [15:0] irqSum_d = {8'h00, portSum, 3'b000, globSum};
  // summary bits are live levels, so a new event can never be lost to a clear
  wire irqAct = |(irqSum_d & irqEn_q);
  wire updAll = &(statIn.updDone | ~statIn.updEnabled);
  wire [15:0] liveStat_d = {14'h0000, statIn.pllUnlocked, updAll};

  // ----------------------------------------
  // clocked state
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pinSel_q <= PIN_SEL_RST;
      irqEn_q <= IRQ_EN_RST;
      globCtrl_q <= GLOB_CTRL_RST;
    end
    else if (wrEn)
    begin
      if (hitSel)
        pinSel_q <= pwdata[15:0];
      if (hitEn)
        irqEn_q <= pwdata[15:0] & IRQ_EN_WMASK;
      if (hitCtrl)
        globCtrl_q <= pwdata[3:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= access;
      pslverr_q <= access && !mapped;
      prdata_q <= (access && !pwrite) ? {16'h0000, rdMux} : 32'h00000000;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pins_q <= '0;
      pinLive_q <= 8'h00;
      irqSum_q <= 16'h0000;
      liveStat_q <= 16'h0000;
      irqOut_q <= 1'b1;
      irqOe_q <= 1'b0;
      updPin_q <= 1'b0;
      errPin_q <= 1'b0;
      refIn_q <= 1'b0;
    end
    else
    begin
      pins_q <= pins_d;
      pinLive_q <= pinLive_d;
      irqSum_q <= irqSum_d;
      liveStat_q <= liveStat_d;
      irqOut_q <= !irqAct;
      irqOe_q <= irqAct || globCtrl_q[CTRL_IDLE_BIT];
      updPin_q <= modeUpd && pinIn[PIN_UPD_IN];
      errPin_q <= errSel && pinIn[PIN_ERR_IN];
      // unselected reference input reads low
      refIn_q <= refInSel && pinIn[PIN_REF_IN];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pinDrive = pins_q;
  assign irqOut = irqOut_q;
  assign irqOe = irqOe_q;
  assign perfUpdatePin = updPin_q;
  assign errInsertPin = errPin_q;
  assign ref8kIn = refIn_q;
endmodule
`default_nettype wire

// file: src/ggr_pkg.sv
/*
  constants, register map and carrier types of the global pin-function
  and interrupt roll-up block.
  assumes an apb master on the system clock and per-port logic outside
  that supplies status selections, interrupt status and update flags.
*/
// How it works
// - 2-bit code: input, status, low, high
// - odd pins A status, even pins B
// - pin 8 is update input in mode 01
// - pin 6 is error-insert input when selected
// - pin 4 is 8 kHz reference input
// - pin 2 drives 8 kHz reference output
// - port summary bit set by port status
// - enabled port summary pulls interrupt low
// - global summary from enabled latched status
// - enabled global summary pulls interrupt low
// - interrupt low active, idle hi-z or high
// - status bit 1 shows pll unlock
// - status bit 0 ANDs enabled update-done flags
// - read register shows live pin levels
package ggr_pkg;
  // ----------------------------------------
  // register map (word indices)
  // ----------------------------------------
  // offsets are word indices: byte address = 4 * index
  localparam logic [11:0] IDX_PIN_SEL = 12'h00a;
  localparam logic [11:0] IDX_IRQ_SUM = 12'h010;
  localparam logic [11:0] IDX_IRQ_EN = 12'h012;
  localparam logic [11:0] IDX_LIVE_STAT = 12'h014;
  localparam logic [11:0] IDX_PIN_READ = 12'h01c;
  localparam logic [11:0] IDX_GLOB_CTRL = 12'h020;
  localparam logic [15:0] PIN_SEL_RST = 16'h0000;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [3:0] GLOB_CTRL_RST = 4'h0;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int PORT_SUM_LSB = 4;
  localparam int GLOB_SUM_BIT = 0;
  localparam int PLL_BIT = 1;
  localparam int UPD_BIT = 0;
  localparam int CTRL_ERR_BIT = 0;
  localparam int CTRL_R8I_BIT = 1;
  localparam int CTRL_R8O_BIT = 2;
  localparam int CTRL_IDLE_BIT = 3;
  localparam logic [1:0] PERF_MODE_PIN = 2'b01;
  localparam int NPINS = 8;
  localparam int NPORTS = 4;
  localparam int PIN_REF_OUT = 1;
  localparam int PIN_REF_IN = 3;
  localparam int PIN_ERR_IN = 5;
  localparam int PIN_UPD_IN = 7;

  typedef enum logic [1:0] {
    FN_INPUT = 2'b00,
    FN_STATUS = 2'b01,
    FN_LOW = 2'b10,
    FN_HIGH = 2'b11
  } ggr_fn_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
  } ggr_pins_t;

  typedef struct packed {
    logic [NPORTS-1:0] portIrqAny;
    logic latchedAny;
    logic pllUnlocked;
    logic [NPORTS-1:0] updDone;
    logic [NPORTS-1:0] updEnabled;
  } ggr_stat_t;
endpackage

// file: dv/ggr_top_monitor.sv
/*
  assertion monitor on the ports of ggr_top.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ggr_top_monitor
  (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [7:0] pinIn,
  input wire ggr_pkg::ggr_pins_t pinDrive,
  input wire ggr_pkg::ggr_stat_t statIn,
  input wire logic [1:0] perfUpdateMode,
  input wire logic perfUpdatePin,
  input wire logic errInsertPin,
  input wire logic ref8kIn,
  input wire logic irqOut,
  input wire logic irqOe
  );
  import ggr_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_req;
    psel && penable && !pready;
  endsequence
  sequence s_quiet;
    statIn.portIrqAny == 4'h0 && !statIn.latchedAny;
  endsequence
  a_ready_one_wait: assert property (s_req |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_irq_drives_low: assert property (!irqOut |-> irqOe)
    else $error("irq low undriven");
  a_irq_clears: assert property (s_quiet [*2] |-> irqOut)
    else $error("irq stuck");
  a_irq_has_cause: assert property ($fell(irqOut) |-> $past(|statIn.portIrqAny || statIn.latchedAny))
    else $error("irq without cause");
  a_upd_pin_take: assert property (perfUpdateMode == PERF_MODE_PIN |=>
    !pinDrive.oe[PIN_UPD_IN] && perfUpdatePin == $past(pinIn[PIN_UPD_IN]))
    else $error("pin 8 not update input");
  a_err_pin_input: assert property (errInsertPin |-> !pinDrive.oe[PIN_ERR_IN])
    else $error("pin 6 driven");
  a_ref_pin_input: assert property (ref8kIn |-> !pinDrive.oe[PIN_REF_IN])
    else $error("pin 4 driven");
endmodule
`default_nettype wire

// file: dv/ggr_board.sv
/*
  board model: pads with outside sources and the interrupt pull-up.
  assumes an undriven pad shows its outside source.
*/
`timescale 1ns/1ns
`default_nettype none
module ggr_board
  (
  input wire ggr_pkg::ggr_pins_t pinDrive,
  input wire logic [7:0] padExt,
  input wire logic irqOut,
  input wire logic irqOe,
  output logic [7:0] pinIn,
  output logic irqLevel
  );
  import ggr_pkg::*;
  // device wins a pad only while enabled
  assign pinIn = (pinDrive.oe & pinDrive.out) | (~pinDrive.oe & padExt);
  // released line floats up through the board pull-up
  assign irqLevel = irqOe ? irqOut : 1'b1;
endmodule
`default_nettype wire

// file: dv/testbench.sv
/*
  bench: apb host, pin and interrupt scenarios, monitor bind.
  assumes the board model feeds pad levels back.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ggr_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ref8kOut = 1'b0, pready, pslverr, perfUpdatePin, errInsertPin, ref8kIn;
  logic irqOut, irqOe, irqLevel;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] pinIn, padExt = 8'ha5;
  logic [3:0] portAStatus = 4'h5, portBStatus = 4'h3;
  logic [1:0] perfUpdateMode = 2'h0;
  ggr_pins_t pinDrive;
  ggr_stat_t statIn = 14'h0;
  int mismatches = 0, checks = 0;
  initial forever #10 mclk = ~mclk;
  ggr_top i_ggr_top (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinIn(pinIn), .pinDrive(pinDrive), .portAStatus(portAStatus), .portBStatus(portBStatus),
    .statIn(statIn), .perfUpdateMode(perfUpdateMode), .ref8kOut(ref8kOut),
    .perfUpdatePin(perfUpdatePin), .errInsertPin(errInsertPin), .ref8kIn(ref8kIn),
    .irqOut(irqOut), .irqOe(irqOe));
  ggr_board i_ggr_board (.pinDrive(pinDrive), .padExt(padExt), .irqOut(irqOut), .irqOe(irqOe),
    .pinIn(pinIn), .irqLevel(irqLevel));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
  // request held until pready is seen at an edge; bounded wait
  task automatic acc(input logic w, input logic [11:0] idx, input logic [31:0] wd, e,
    input logic er);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1 && n++ < 40);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40)
    begin
      mismatches++;
      stop_test();
    end
    if (!w)
      `CHK("rdata", e, prdata);
    `CHK("slverr", er, pslverr);
  endtask
  task automatic t_regs;
    acc(1'b1, 12'h3ff, 32'hffff, 32'h0, 1'b1);
    acc(1'b0, IDX_PIN_SEL, 32'h0, {16'h0, PIN_SEL_RST}, 1'b0);
    acc(1'b0, IDX_IRQ_EN, 32'h0, {16'h0, IRQ_EN_RST}, 1'b0);
    acc(1'b0, 12'h3ff, 32'h0, 32'h0, 1'b1);
    acc(1'b1, IDX_IRQ_EN, 32'hffff, 32'h0, 1'b0);
    acc(1'b0, IDX_IRQ_EN, 32'h0, 32'hf1, 1'b0);
  endtask
  task automatic t_pins;
    logic [15:0] sel [4] = '{16'haaaa, 16'hffff, 16'h0000, 16'h5555};
    logic [7:0] eo [4] = '{8'h00, 8'hff, 8'h00, 8'h00};
    for (int k = 0; k < 4; k++)
      eo[3][2*k +: 2] = {portBStatus[k], portAStatus[k]};
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, IDX_PIN_SEL, {16'h0, sel[i]}, 32'h0, 1'b0);
      repeat (2) @(posedge mclk);
      `CHK("oe", i == 2 ? 8'h00 : 8'hff, pinDrive.oe);
      if (i != 2)
        `CHK("out", eo[i], pinDrive.out);
      acc(1'b0, IDX_PIN_READ, 32'h0, {24'h0, i == 2 ? padExt : eo[i]}, 1'b0);
    end
  endtask
  task automatic t_take;
    acc(1'b1, IDX_GLOB_CTRL, 32'h7, 32'h0, 1'b0);
    perfUpdateMode <= PERF_MODE_PIN;
    for (int i = 0; i < 2; i++)
    begin
      padExt <= i ? 8'h5a : 8'ha5;
      ref8kOut <= i[0];
      repeat (3) @(posedge mclk);
      `CHK("oe", 8'h57, pinDrive.oe);
      `CHK("ref", ref8kOut, pinDrive.out[PIN_REF_OUT]);
      `CHK("upd", padExt[PIN_UPD_IN], perfUpdatePin);
      `CHK("err", padExt[PIN_ERR_IN], errInsertPin);
      `CHK("refin", padExt[PIN_REF_IN], ref8kIn);
    end
    perfUpdateMode <= 2'h2;
    acc(1'b1, IDX_GLOB_CTRL, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk);
    `CHK("oe", 8'hff, pinDrive.oe);
  endtask
  task automatic t_irq;
    for (int p = 0; p < 4; p++)
    begin
      statIn.portIrqAny <= 4'h1 << p;
      repeat (2) @(posedge mclk);
      `CHK("irq", 1'b0, irqOut);
      acc(1'b0, IDX_IRQ_SUM, 32'h0, 32'h10 << p, 1'b0);
    end
    acc(1'b1, IDX_IRQ_EN, 32'h1, 32'h0, 1'b0);
    repeat (2) @(posedge mclk);
    `CHK("mask", 1'b1, irqOut);
    statIn.latchedAny <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("glob", 1'b0, irqOut);
    `CHK("level", 1'b0, irqLevel);
    acc(1'b0, IDX_IRQ_SUM, 32'h0, 32'h81, 1'b0);
    acc(1'b1, IDX_IRQ_EN, 32'h0, 32'h0, 1'b0);
    repeat (2) @(posedge mclk);
    `CHK("gmask", 1'b1, irqOut);
    acc(1'b1, IDX_IRQ_EN, 32'h1, 32'h0, 1'b0);
    statIn <= 14'h0;
    repeat (2) @(posedge mclk);
    `CHK("idle", 2'b10, {irqOut, irqOe});
    acc(1'b1, IDX_GLOB_CTRL, 32'h8, 32'h0, 1'b0);
    repeat (2) @(posedge mclk);
    `CHK("high", 3'b111, {irqOut, irqOe, irqLevel});
  endtask
  task automatic t_stat;
    statIn.pllUnlocked <= 1'b1;
    statIn.updEnabled <= 4'h3;
    statIn.updDone <= 4'h7;
    acc(1'b0, IDX_LIVE_STAT, 32'h0, 32'h3, 1'b0);
    statIn.updDone <= 4'h6;
    acc(1'b0, IDX_LIVE_STAT, 32'h0, 32'h2, 1'b0);
    statIn.pllUnlocked <= 1'b0;
    statIn.updDone <= 4'hb;
    acc(1'b0, IDX_LIVE_STAT, 32'h0, 32'h1, 1'b0);
  endtask
  // mid-run reset: outputs return to their idle values
  task automatic t_rst;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("rstpins", 16'h0000, pinDrive);
    `CHK("rstirq", 2'b10, {irqOut, irqOe});
    rst <= 1'b0;
    acc(1'b0, IDX_GLOB_CTRL, 32'h0, {28'h0, GLOB_CTRL_RST}, 1'b0);
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_pins();
    t_take();
    t_irq();
    t_stat();
    t_rst();
    stop_test();
  end
endmodule
bind ggr_top ggr_top_monitor i_ggr_top_monitor (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pinIn(pinIn), .pinDrive(pinDrive), .statIn(statIn),
  .perfUpdateMode(perfUpdateMode), .perfUpdatePin(perfUpdatePin),
  .errInsertPin(errInsertPin), .ref8kIn(ref8kIn), .irqOut(irqOut), .irqOe(irqOe));
`default_nettype wire
